// file: rtl/cesp_pkg.sv
// Constants shared by the serial programming port of the configuration EEPROM.
// Summary of operation
// - Messages framed by start/stop, bytes plus acknowledge.
// - Data line only pulled low or released.
// - Array starts zero, changes only by writes.
// - Data changes only while clock is low.
// - Start falls, stop rises, clock high.
// - Start condition resets port to device-address state.
// - Stop launches timed write; lines then ignored.
// - Receiver acknowledges low, refuses by releasing.
// - Accepted bytes end with acknowledge or stop.
// - New driver takes line before next rise.
// - Addresses sent MSB first, data LSB first.
// - Chip enable plays no part in selection.
// - Three address bytes, each acknowledged.
// - Read/write bit: zero write, one read.
// - Page writes wrap within 128 bytes.
// - No acknowledge during internal write cycle.
// - Reads continue while programmer acknowledges.
package cesp_pkg;
  localparam int ADDR_W = 17;
  localparam int PAGE_BITS = 7;
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam int CLK_MHZ = 100;
  localparam int WRITE_CYCLE_TIME_US = 5000;
  localparam int WRITE_CYCLES = WRITE_CYCLE_TIME_US * CLK_MHZ;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h00000;
  typedef enum logic [2:0] {
    CESP_IDLE, CESP_DEV, CESP_ADDR, CESP_WDATA, CESP_RDATA, CESP_RACK,
    CESP_WAIT, CESP_BUSY
  } cesp_state_t;
endpackage : cesp_pkg

// file: rtl/cesp_port.sv
// Serial programming port of the configuration EEPROM.
`timescale 1ns/10ps
module cesp_port #(
  parameter int WRITE_CYCLES = cesp_pkg::WRITE_CYCLES,
  parameter int DEPTH = 131072
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Programming pins.
  input wire logic serial_mode_enable_n_i,
  input wire logic prog_serial_clock_i,
  input wire logic prog_serial_data_i,
  output logic prog_serial_data_o,
  output logic prog_serial_data_oe_o,
  // Status.
  output logic busy_o
);
  localparam int AW = cesp_pkg::ADDR_W;
  if (WRITE_CYCLES < 1 || DEPTH > (1 << AW) || DEPTH < 128) begin : g_bad
    $error("cesp_port: bad parameters");
  end

  logic [2:0] scl_s, sda_s, en_s;
  logic [2:0] next_scl_s, next_sda_s, next_en_s;
  always_comb begin
    next_scl_s = {scl_s[1:0], prog_serial_clock_i};
    next_sda_s = {sda_s[1:0], prog_serial_data_i};
    next_en_s = {en_s[1:0], serial_mode_enable_n_i};
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      en_s <= 3'h7;
    end else begin
      scl_s <= next_scl_s;
      sda_s <= next_sda_s;
      en_s <= next_en_s;
    end
  end
  wire logic scl = scl_s[1];
  wire logic sda = sda_s[1];
  wire logic prog_mode = ~en_s[1];
  wire logic scl_rise = scl_s[1] & ~scl_s[2];
  wire logic scl_fall = ~scl_s[1] & scl_s[2];
  wire logic start_c = scl & scl_s[2] & ~sda & sda_s[2];
  wire logic stop_c = scl & scl_s[2] & sda & ~sda_s[2];

  logic [7:0] mem [DEPTH] = '{default: 8'h00};
  cesp_pkg::cesp_state_t st, next_st;
  logic [3:0] bitc, next_bitc;
  logic [7:0] sh, next_sh;
  logic [1:0] abyte, next_abyte;
  logic [AW-1:0] addr, next_addr;
  logic in_ack, next_in_ack;
  logic drive_low, next_drive_low;
  logic wr_pend, next_wr_pend;
  logic [31:0] wcnt, next_wcnt;
  logic we;

  function automatic logic [AW-1:0] page_inc(input logic [AW-1:0] a);
    page_inc = {a[AW-1:7], a[6:0] + 7'h01};
  endfunction

  always_comb begin
    next_st = st;
    next_bitc = bitc;
    next_sh = sh;
    next_abyte = abyte;
    next_addr = addr;
    next_in_ack = in_ack;
    next_drive_low = drive_low;
    next_wr_pend = wr_pend;
    next_wcnt = wcnt;
    we = 1'b0;
    if (!prog_mode) begin
      next_st = cesp_pkg::CESP_IDLE;
      next_drive_low = 1'b0;
      next_wr_pend = 1'b0;
    end else if (st == cesp_pkg::CESP_BUSY) begin
      next_drive_low = 1'b0;
      if (wcnt >= 32'(WRITE_CYCLES - 1)) begin
        next_st = cesp_pkg::CESP_IDLE;
      end else begin
        next_wcnt = wcnt + 32'h1;
      end
    end else if (start_c) begin
      next_st = cesp_pkg::CESP_DEV;
      next_bitc = 4'h0;
      next_in_ack = 1'b0;
      next_drive_low = 1'b0;
      next_wr_pend = 1'b0;
    end else if (stop_c) begin
      next_drive_low = 1'b0;
      next_wcnt = 32'h0;
      next_st = wr_pend ? cesp_pkg::CESP_BUSY : cesp_pkg::CESP_IDLE;
      next_wr_pend = 1'b0;
    end else if (st != cesp_pkg::CESP_IDLE && st != cesp_pkg::CESP_WAIT) begin
      if (scl_rise && !in_ack) begin
        if (st == cesp_pkg::CESP_WDATA) begin
          next_sh = {sda, sh[7:1]};
        end else if (st != cesp_pkg::CESP_RDATA) begin
          next_sh = {sh[6:0], sda};
        end
        next_bitc = bitc + 4'h1;
      end else if (scl_rise && in_ack && st == cesp_pkg::CESP_RACK) begin
        if (sda) begin
          next_st = cesp_pkg::CESP_WAIT;
        end
      end else if (scl_fall) begin
        next_drive_low = 1'b0;
        if (in_ack) begin
          next_in_ack = 1'b0;
          next_bitc = 4'h0;
          if (st == cesp_pkg::CESP_RACK) begin
            next_st = cesp_pkg::CESP_RDATA;
            next_sh = mem[addr];
            next_addr = addr + 17'h1;
          end
          if (st == cesp_pkg::CESP_RDATA) begin
            next_sh = mem[addr];
            next_addr = addr + 17'h1;
          end
          if (st == cesp_pkg::CESP_RDATA || st == cesp_pkg::CESP_RACK) begin
            next_drive_low = ~mem[addr][0];
          end
        end else if (st == cesp_pkg::CESP_RDATA && bitc != 4'h8) begin
          next_drive_low = ~sh[bitc[2:0]];
        end else if (st == cesp_pkg::CESP_RDATA) begin
          next_in_ack = 1'b1;
          next_st = cesp_pkg::CESP_RACK;
        end else if (bitc == 4'h8) begin
          next_in_ack = 1'b1;
          next_drive_low = 1'b1;
          unique case (st)
            cesp_pkg::CESP_DEV: begin
              if (sh[7:1] != cesp_pkg::DEV_ADDR) begin
                next_drive_low = 1'b0;
                next_st = cesp_pkg::CESP_WAIT;
              end else if (sh[0]) begin
                next_st = cesp_pkg::CESP_RDATA;
              end else begin
                next_st = cesp_pkg::CESP_ADDR;
                next_abyte = 2'h0;
              end
            end
            cesp_pkg::CESP_ADDR: begin
              next_addr = {addr[AW-9:0], sh};
              next_abyte = abyte + 2'h1;
              if (abyte == 2'h2) begin
                next_st = cesp_pkg::CESP_WDATA;
              end
            end
            cesp_pkg::CESP_WDATA: begin
              we = 1'b1;
              next_addr = page_inc(addr);
              next_wr_pend = 1'b1;
            end
            default: begin
              next_drive_low = 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= cesp_pkg::CESP_IDLE;
      bitc <= 4'h0;
      sh <= 8'h00;
      abyte <= 2'h0;
      addr <= cesp_pkg::ADDR_RESET;
      in_ack <= 1'b0;
      drive_low <= 1'b0;
      wr_pend <= 1'b0;
      wcnt <= 32'h0;
    end else begin
      st <= next_st;
      bitc <= next_bitc;
      sh <= next_sh;
      abyte <= next_abyte;
      addr <= next_addr;
      in_ack <= next_in_ack;
      drive_low <= next_drive_low;
      wr_pend <= next_wr_pend;
      wcnt <= next_wcnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (we) begin
      mem[addr[$clog2(DEPTH)-1:0]] <= sh;
    end
  end

  assign prog_serial_data_o = 1'b0;
  assign prog_serial_data_oe_o = drive_low;
  assign busy_o = (st == cesp_pkg::CESP_BUSY);

  a_busy_no_ack: assert property (
    @(posedge clk_i) disable iff (rst_i)
    busy_o |-> ##1 !prog_serial_data_oe_o)
    else $error("acknowledge driven while busy");
  a_disabled_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !prog_mode |=> (st == cesp_pkg::CESP_IDLE))
    else $error("machine not idle with mode disabled");
  a_start_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (prog_mode && start_c && st != cesp_pkg::CESP_BUSY)
    |=> (st == cesp_pkg::CESP_DEV && !prog_serial_data_oe_o))
    else $error("start did not reset the port");
  a_stop_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (prog_mode && stop_c && wr_pend && st != cesp_pkg::CESP_BUSY)
    |=> busy_o)
    else $error("stop after write did not start write cycle");
  a_drive_clock_low: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(prog_serial_data_oe_o) |-> !scl)
    else $error("data drive raised while clock high");
  a_idle_released: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (st == cesp_pkg::CESP_IDLE || st == cesp_pkg::CESP_WAIT)
    |-> !prog_serial_data_oe_o)
    else $error("data driven while idle or waiting");
endmodule : cesp_port

// file: verification/cesp_prog_model.sv
// Behavioural programmer driving the serial clock and data pins.
`timescale 1ns/10ps
module cesp_prog_model (
  // Clock and resolved data wire.
  input wire logic clk_i,
  input wire logic sda_i,
  // Programmer pins.
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask : w
  task automatic start;
    w(4);
    sda_low_o = 1'b0;
    w(4);
    scl_o = 1'b1;
    w(8);
    sda_low_o = 1'b1;
    w(8);
    scl_o = 1'b0;
  endtask : start
  task automatic stop;
    w(4);
    sda_low_o = 1'b1;
    w(4);
    scl_o = 1'b1;
    w(8);
    sda_low_o = 1'b0;
    w(8);
  endtask : stop
  // Data changes only in the low half of each serial clock period.
  task automatic xfer(input logic [7:0] d, input bit lsb, input bit mack,
                      output logic [7:0] q, output logic ack);
    int k;
    for (int i = 0; i < 9; i++) begin
      k = lsb ? i : 7 - i;
      w(4);
      sda_low_o = (i < 8) ? ~d[k] : mack;
      w(4);
      scl_o = 1'b1;
      w(8);
      if (i < 8) q[k] = sda_i;
      else ack = ~sda_i;
      scl_o = 1'b0;
    end
  endtask : xfer
endmodule : cesp_prog_model

// file: verification/cesp_port_test.sv
// Self-checking bench for the serial programming port.
`timescale 1ns/10ps
module cesp_port_test;
  localparam int WCYC = 400;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic mode_en_n = 1'b0;
  logic scl, low, sda_o, oe, busy, ack;
  logic [7:0] q;
  logic [7:0] mem [int];
  logic [16:0] seed = 17'd96657;
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    lfsr = {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  int err_total = 0;
  int checks_done = 0;
  wire logic sda = ~((oe & ~sda_o) | low);
  always #5 clk_i = ~clk_i;
  cesp_port #(.WRITE_CYCLES(WCYC)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .serial_mode_enable_n_i(mode_en_n), .prog_serial_clock_i(scl),
    .prog_serial_data_i(sda), .prog_serial_data_o(sda_o),
    .prog_serial_data_oe_o(oe), .busy_o(busy));
  cesp_prog_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(low));
  task automatic chk1(input logic g, input logic e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t bit %b exp %b", $time, g, e);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t byte %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic results;
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task automatic sb(input logic [7:0] b, input bit lsb, input logic e);
    m.xfer(b, lsb, 1'b0, q, ack);
    chk1(ack, e);
  endtask : sb
  task automatic setaddr(input logic [16:0] a);
    m.start;
    sb({cesp_pkg::DEV_ADDR, 1'b0}, 0, 1);
    sb({7'h00, a[16]}, 0, 1);
    sb(a[15:8], 0, 1);
    sb(a[7:0], 0, 1);
  endtask : setaddr
  task automatic wpage(input logic [16:0] a, input int n);
    setaddr(a);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      mem[{a[16:7], 7'(a[6:0] + i)}] = seed[7:0];
      sb(seed[7:0], 1, 1);
    end
    m.stop;
    chk1(busy, 1'b1);
    m.start;
    sb({cesp_pkg::DEV_ADDR, 1'b0}, 0, 0);
    for (int i = 0; i < WCYC && busy !== 1'b0; i++) @(negedge clk_i);
    chk1(busy, 1'b0);
  endtask : wpage
  task automatic rd(input logic [16:0] a, input int n);
    setaddr(a);
    m.start;
    sb({cesp_pkg::DEV_ADDR, 1'b1}, 0, 1);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hff, 1, i < n - 1, q, ack);
      chk8(q, mem.exists(a + i) ? mem[a + i] : 8'h00);
    end
    m.stop;
    chk1(busy, 1'b0);
  endtask : rd
  initial begin
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    chk1(oe, 1'b0);
    chk1(sda_o, 1'b0);
    repeat (4) @(negedge clk_i);
    m.start;
    sb(8'h42, 0, 0);
    wpage(17'h1fffc, 6);
    rd(17'h1ff80, 3);
    rd(17'h1fffc, 4);
    wpage(17'h00100, 2);
    rd(17'h000ff, 4);
    wpage(17'h00180, 128);
    rd(17'h001fe, 4);
    mode_en_n = 1'b1;
    m.start;
    sb({cesp_pkg::DEV_ADDR, 1'b0}, 0, 0);
    results;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    results;
  end
endmodule : cesp_port_test
